// ---- bench/cmpev_core_model.sv ----
// Behavioural model of the analog comparator core behind the block.
`timescale 1ns/10ps
module cmpev_core_model
(
   input  wire logic ref_clk,
   input  wire logic target,
   input  wire logic slow,
   output logic      comparator_output
);
   logic [2:0] wait_cnt;  // Settling cycles still to go.

   // The output follows the wanted level after one cycle, or after four
   // more when slow, so the synchroniser sees late and early changes.
   always @(posedge ref_clk)
   begin
      if (comparator_output === target)
         wait_cnt <= slow ? 3'h4 : 3'h0;
      else if (wait_cnt == 3'h0)
         comparator_output <= target;
      else
         wait_cnt <= wait_cnt - 3'h1;
   end

   // A settled low level at power-up.
   initial
   begin
      comparator_output = 1'b0;
      wait_cnt = 3'h0;
   end
endmodule

// ---- bench/tb_cmpev_top.sv ----
// Self-checking bench for the comparator event control block.
`timescale 1ns/10ps
module tb_cmpev_top
   import cmpev_pkg::*;
;
   logic        ref_clk, rst, psel, penable, pwrite, target, slow;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, err, cmp_out, irq, trigger_pulse;
   logic        pos_src_ref, pos_src_pin, pos_src_gnd, neg_src_gnd;
   logic [3:0]  neg_src_pin;
   logic        opamp_enable, adjusted_output, alt_pos_gnd, alt_neg_gnd;
   int          num_errors, samples_checked, trig_cnt, cycles;

   // Free-running 10 MHz clock.
   initial
   begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   cmpev_core_model cmpev_core_model_i (.ref_clk(ref_clk), .target(target),
      .slow(slow), .comparator_output(cmp_out));

   cmpev_top cmpev_top_i (.ref_clk(ref_clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .comparator_output(cmp_out), .pos_src_ref(pos_src_ref),
      .pos_src_pin(pos_src_pin), .pos_src_gnd(pos_src_gnd),
      .neg_src_pin(neg_src_pin), .neg_src_gnd(neg_src_gnd),
      .opamp_enable(opamp_enable), .adjusted_output(adjusted_output),
      .trigger_pulse(trigger_pulse), .irq(irq));

   // A variant without positive pin or reference and only pins 0 and 2;
   // it shares the bus so every write lands in both copies.
   cmpev_top #(.POS_PIN_AVAIL(1'b0), .REF_AVAIL(1'b0), .NEG_PIN_AVAIL(4'h5))
      cmpev_top_sparse_i (.ref_clk(ref_clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(), .pready(), .pslverr(), .comparator_output(cmp_out),
      .pos_src_ref(), .pos_src_pin(), .pos_src_gnd(alt_pos_gnd),
      .neg_src_pin(), .neg_src_gnd(alt_neg_gnd), .opamp_enable(),
      .adjusted_output(), .trigger_pulse(), .irq());

   // Counts trigger pulses and cuts a hang short.
   always @(posedge ref_clk)
   begin
      if (trigger_pulse === 1'b1)
         trig_cnt++;
      cycles++;
      if (cycles == 20000)
      begin
         num_errors++;
         $display("MISMATCH t=%0t run timed out", $time);
         close_out();
      end
   end

   task automatic chk_reg(input logic [31:0] got, exp, input string what);
      samples_checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_pin(input logic got, exp, input string what);
      chk_reg({31'h0, got}, {31'h0, exp}, what);
   endtask

   // One APB transfer; waits for pready, takes data at that edge only.
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      // No cycle limit here; only the bench timeout ends a hung wait.
      do
         @(posedge ref_clk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk_reg(rd, exp, "register read");
   endtask

   // Arms one mode, moves the comparator, checks flags and pulses.
   task automatic edge_case(input logic [1:0] m, input logic inv, lvl, ev);
      logic [31:0] c;
      c = (32'(m) << 6) | (32'(inv) << 13) | (32'(inv) << 10);
      apb(1'b1, CMPEV_OFF_CTRL, c);
      apb(1'b1, CMPEV_OFF_IRQ_ST, 32'h4);
      trig_cnt = 0;
      slow <= inv;
      target <= lvl;
      repeat (16) @(posedge ref_clk);
      chk_reg(32'(trig_cnt), {31'h0, ev}, "trigger count");
      chk_pin(adjusted_output, lvl ^ inv, "adjusted output");
      rd_chk(CMPEV_OFF_CTRL, c | (32'(ev) << 9));
      rd_chk(CMPEV_OFF_IRQ_ST, {29'h0, ev, 2'h0});
      rd_chk(CMPEV_OFF_STATUS, {30'h0, lvl, lvl ^ inv});
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Main sequence.
   initial
   begin
      logic a;
      {psel, penable, pwrite, paddr, pwdata, target, slow} = '0;
      {num_errors, samples_checked, trig_cnt, cycles} = '0;
      rst = 1'b1;
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      rd_chk(CMPEV_OFF_CTRL, 32'h0);
      rd_chk(CMPEV_OFF_IRQ_MK, 32'h0);
      rd_chk(8'h10, 32'h0);
      chk_pin(err, 1'b1, "unmapped error");
      $display("test reset done");
      // Unimplemented bits stay zero even when written with ones.
      apb(1'b1, CMPEV_OFF_CTRL, 32'hFFFFFFFF);
      rd_chk(CMPEV_OFF_CTRL, 32'(CMPEV_CTRL_WMASK));
      @(negedge ref_clk);
      chk_pin(opamp_enable, 1'b1, "opamp on");
      $display("test loose bits done");
      for (int c = 0; c < 4; c++)
      begin
         apb(1'b1, CMPEV_OFF_CTRL, 32'(c) | (32'(c & 1) << 4));
         @(negedge ref_clk);
         chk_reg(32'(neg_src_pin), 32'h1 << c, "neg pin");
         chk_pin(neg_src_gnd, 1'b0, "neg gnd");
         chk_pin(alt_neg_gnd, !(c == 0 || c == 2), "sparse neg");
         chk_pin(pos_src_ref, c[0], "pos ref");
         chk_pin(pos_src_pin, !c[0], "pos pin");
         chk_pin(alt_pos_gnd, 1'b1, "sparse pos");
         chk_pin(pos_src_gnd, 1'b0, "pos gnd");
         chk_pin(opamp_enable, 1'b0, "opamp off");
      end
      $display("test routing done");
      for (int m = 0; m < 4; m++)
         for (int i = 0; i < 2; i++)
            for (int l = 1; l >= 0; l--)
            begin
               a = l[0] ^ i[0];
               edge_case(m[1:0], i[0], l[0], m == 3 || (m == 1 && a) ||
                         (m == 2 && !a));
            end
      $display("test edge modes done");
      // Flags are cleared before the interrupt is unmasked.
      apb(1'b1, CMPEV_OFF_CTRL, 32'h40);
      apb(1'b1, CMPEV_OFF_IRQ_ST, 32'h4);
      apb(1'b1, CMPEV_OFF_IRQ_MK, 32'h4);
      @(negedge ref_clk);
      chk_pin(irq, 1'b0, "irq idle");
      target <= 1'b1;
      repeat (16) @(posedge ref_clk);
      chk_pin(irq, 1'b1, "irq raised");
      trig_cnt = 0;
      target <= 1'b0;
      repeat (10) @(posedge ref_clk);
      target <= 1'b1;
      repeat (16) @(posedge ref_clk);
      chk_reg(32'(trig_cnt), 32'h0, "blocked event");
      apb(1'b1, CMPEV_OFF_IRQ_ST, 32'h4);
      @(negedge ref_clk);
      chk_pin(irq, 1'b0, "irq cleared");
      apb(1'b1, CMPEV_OFF_IRQ_MK, 32'h0);
      edge_case(2'h3, 1'b0, 1'b0, 1'b1);
      chk_pin(irq, 1'b0, "irq masked");
      $display("test interrupt done");
      close_out();
   end
endmodule

// ---- design/cmpev_edge.sv ----
// Edge qualifier turning filtered comparator changes into event requests.
`timescale 1ns/10ps
module cmpev_edge
   import cmpev_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic rst,
   cmpev_evt_if.detect ev
);
   logic prev;      // Level seen one cycle before.
   logic raw_rise;  // Raw output went low to high.
   logic raw_fall;  // Raw output went high to low.
   logic hit;       // Transition matches the edge mode.

   // Remember the previous level for edge detection.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         prev <= 1'b0;
      else
         prev <= ev.level;
   end

   assign raw_rise = ev.level & ~prev;
   assign raw_fall = ~ev.level & prev;

   // Edges are taken from the raw level and mapped through polarity, so a
   // change of the invert bit alone never looks like a transition.
   always_comb
   begin
      hit = 1'b0;
      case (ev.edge_sel)
         CMPEV_EDGE_ANY:  hit = raw_rise | raw_fall;
         CMPEV_EDGE_FALL: hit = ev.invert ? raw_rise : raw_fall;
         CMPEV_EDGE_RISE: hit = ev.invert ? raw_fall : raw_rise;
         default:         hit = 1'b0;
      endcase
   end

   // A set event flag holds off every further request.
   assign ev.event_req = hit & ~ev.event_flag;
endmodule

// ---- design/cmpev_evt_if.sv ----
// Interface carrying the event qualification signals between modules.
`timescale 1ns/10ps
interface cmpev_evt_if;
   import cmpev_pkg::*;
   logic        level;       // Filtered raw comparator output.
   cmpev_edge_t edge_sel;    // Selected event edge mode.
   logic        invert;      // Output polarity invert.
   logic        event_flag;  // Sticky event flag that blocks events.
   logic        event_req;   // One-cycle qualified event.

   // Edge detector side.
   modport detect
   (
      input  level,
      input  edge_sel,
      input  invert,
      input  event_flag,
      output event_req
   );

   // Control side.
   modport ctrl
   (
      output level,
      output edge_sel,
      output invert,
      output event_flag,
      input  event_req
   );
endinterface

// ---- design/cmpev_pkg.sv ----
// Package of register map, field positions and reset values for cmpev.
package cmpev_pkg;

   // Byte offsets of the APB registers.
   localparam logic [7:0] CMPEV_OFF_CTRL   = 8'h00;
   localparam logic [7:0] CMPEV_OFF_IRQ_ST = 8'h04;
   localparam logic [7:0] CMPEV_OFF_IRQ_MK = 8'h08;
   localparam logic [7:0] CMPEV_OFF_STATUS = 8'h0C;

   // Field positions inside comparator_control.
   localparam int CMPEV_CTRL_W        = 16;
   localparam int CMPEV_BIT_POLINV    = 13;
   localparam int CMPEV_BIT_OPAMP     = 10;
   localparam int CMPEV_BIT_EVFLAG    = 9;
   localparam int CMPEV_BIT_EDGE_HI   = 7;
   localparam int CMPEV_BIT_EDGE_LO   = 6;
   localparam int CMPEV_BIT_REFSEL    = 4;
   localparam int CMPEV_BIT_CHAN_HI   = 1;
   localparam int CMPEV_BIT_CHAN_LO   = 0;

   // Writable bits of comparator_control; bits 5, 3 and 2 never store.
   localparam logic [15:0] CMPEV_CTRL_WMASK = 16'h26D3;
   localparam logic [15:0] CMPEV_CTRL_RESET = 16'h0000;

   // Interrupt status and mask layout.
   localparam int          CMPEV_IRQ_BIT_CMP = 2;
   localparam logic [2:0]  CMPEV_IRQ_WMASK   = 3'h4;
   localparam logic [2:0]  CMPEV_IRQ_RESET   = 3'h0;

   // Status register layout.
   localparam int CMPEV_ST_BIT_ADJ = 0;
   localparam int CMPEV_ST_BIT_RAW = 1;

   // Edge select encodings.
   typedef enum logic [1:0]
   {
      CMPEV_EDGE_OFF  = 2'h0,
      CMPEV_EDGE_RISE = 2'h1,
      CMPEV_EDGE_FALL = 2'h2,
      CMPEV_EDGE_ANY  = 2'h3
   } cmpev_edge_t;

endpackage

// ---- design/cmpev_sync.sv ----
// Three-stage synchroniser with agreement filter for the comparator pin.
`timescale 1ns/10ps
module cmpev_sync
(
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic async_in,
   output logic      level
);
   logic s1;  // First stage, read only by the second.
   logic s2;  // Second stage.
   logic s3;  // Third stage.

   // Shift the pin through three flops.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
      end
      else
      begin
         s1 <= async_in;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // Accept a new level only when stages two and three agree.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         level <= 1'b0;
      else if (s2 == s3)
         level <= s3;
   end
endmodule

// ---- design/cmpev_top.sv ----
// Comparator channel control register, input routing and event logic.
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/10ps
// Function
// - Mode 11 signals any output change.
// - Mode 10 signals falling adjusted output.
// - Mode 01 signals rising adjusted output.
// - Mode 00 signals nothing at all.
// - Bits 5, 3, 2 read zero.
// - Reference bit picks positive input source.
// - Channel field picks one of four negatives.
// - Missing selected source is tied to ground.
// - Op amp enable leaves comparator working.
module cmpev_top
   import cmpev_pkg::*;
#(
   parameter logic       POS_PIN_AVAIL = 1'b1,    // Positive pin present.
   parameter logic       REF_AVAIL     = 1'b1,    // Internal ref present.
   parameter logic [3:0] NEG_PIN_AVAIL = 4'hF     // Negative pins present.
)
(
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        comparator_output,
   output logic             pos_src_ref,
   output logic             pos_src_pin,
   output logic             pos_src_gnd,
   output logic [3:0]       neg_src_pin,
   output logic             neg_src_gnd,
   output logic             opamp_enable,
   output logic             adjusted_output,
   output logic             trigger_pulse,
   output logic             irq
);
   cmpev_evt_if ev ();               // Link to the edge qualifier.
   logic [15:0] ctrl;                // comparator_control storage.
   logic [2:0]  irq_status;          // Sticky interrupt status.
   logic [2:0]  irq_mask;            // Interrupt mask.
   logic        level;               // Filtered raw comparator output.
   logic        setup;               // APB setup phase.
   logic        wr_acc;              // APB write takes effect.
   logic        addr_ok;             // Address is mapped.
   logic [31:0] next_rdata;          // Read data for the current setup.
   logic [1:0]  chan;                // Negative channel select field.
   logic [2:0]  next_irq_status;     // Status value for the next edge.
   logic [2:0]  next_irq_mask;       // Mask value for the next edge.

   // Every check below runs on the block clock and rests during reset.
   default clocking cmpev_cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   // Filter the asynchronous comparator output.
   cmpev_sync u_sync
   (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .async_in (comparator_output),
      .level    (level)
   );

   // Qualify transitions against the edge mode and event flag.
   cmpev_edge u_edge
   (
      .ref_clk (ref_clk),
      .rst     (rst),
      .ev      (ev.detect)
   );

   assign ev.level      = level;
   assign ev.edge_sel   = cmpev_edge_t'(ctrl[CMPEV_BIT_EDGE_HI:
                                             CMPEV_BIT_EDGE_LO]);
   assign ev.invert     = ctrl[CMPEV_BIT_POLINV];
   assign ev.event_flag = ctrl[CMPEV_BIT_EVFLAG];

   // The slave never waits, so every access finishes in one access cycle.
   assign pready  = 1'b1;
   assign setup   = psel & ~penable;
   assign wr_acc  = psel & penable & pready & pwrite;
   assign addr_ok = (paddr == CMPEV_OFF_CTRL) ||
                    (paddr == CMPEV_OFF_IRQ_ST) ||
                    (paddr == CMPEV_OFF_IRQ_MK) ||
                    (paddr == CMPEV_OFF_STATUS);

   // Control register; unimplemented bits are masked off on write.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         ctrl <= CMPEV_CTRL_RESET;
      else
      begin
         if (wr_acc && paddr == CMPEV_OFF_CTRL)
         begin
            ctrl <= pwdata[15:0] & CMPEV_CTRL_WMASK;
         end
         // An event in the same cycle as a clearing write still wins.
         if (ev.event_req)
         begin
            ctrl[CMPEV_BIT_EVFLAG] <= 1'b1;
         end
      end
   end

   // Next status and mask; a new event wins over a clearing write in the
   // same cycle, so a clearing write never drops the status bit of that event.
   always_comb
   begin
      next_irq_status = irq_status;
      next_irq_mask   = irq_mask;
      if (wr_acc && paddr == CMPEV_OFF_IRQ_ST)
      begin
         next_irq_status = irq_status & ~(pwdata[2:0] & CMPEV_IRQ_WMASK);
      end
      if (wr_acc && paddr == CMPEV_OFF_IRQ_MK)
      begin
         next_irq_mask = pwdata[2:0] & CMPEV_IRQ_WMASK;
      end
      if (ev.event_req)
      begin
         next_irq_status[CMPEV_IRQ_BIT_CMP] = 1'b1;
      end
   end

   // Interrupt status: set by events, cleared by writing ones.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         irq_status <= CMPEV_IRQ_RESET;
      else
         irq_status <= next_irq_status;
   end

   // Interrupt mask register.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         irq_mask <= CMPEV_IRQ_RESET;
      else
         irq_mask <= next_irq_mask;
   end

   // Level interrupt, high while an unmasked status bit is set; it looks
   // at the next values so that it never lags the flops by a cycle.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         irq <= 1'b0;
      else
         irq <= |(next_irq_status & next_irq_mask);
   end

   // Trigger pulse one cycle after the qualified transition.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         trigger_pulse <= 1'b0;
      else
         trigger_pulse <= ev.event_req;
   end

   // Polarity-adjusted output, registered for software and other logic.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         adjusted_output <= 1'b0;
      else
         adjusted_output <= level ^ ctrl[CMPEV_BIT_POLINV];
   end

   // Read data mux, evaluated during the setup phase.
   always_comb
   begin
      next_rdata = 32'h0000_0000;
      if (paddr == CMPEV_OFF_CTRL)
         next_rdata = {16'h0000, ctrl & CMPEV_CTRL_WMASK};
      else if (paddr == CMPEV_OFF_IRQ_ST)
         next_rdata = {29'h0, irq_status};
      else if (paddr == CMPEV_OFF_IRQ_MK)
         next_rdata = {29'h0, irq_mask};
      else if (paddr == CMPEV_OFF_STATUS)
         next_rdata = {30'h0, level, adjusted_output};
   end

   // Read data and error are captured at the setup edge and held through
   // the access cycle, so outputs come from flops.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else if (setup)
      begin
         prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
         pslverr <= ~addr_ok;
      end
   end

   // Source routing; a selected source that is absent goes to ground.
   assign chan = ctrl[CMPEV_BIT_CHAN_HI:CMPEV_BIT_CHAN_LO];

   always_comb
   begin
      pos_src_ref = 1'b0;
      pos_src_pin = 1'b0;
      pos_src_gnd = 1'b0;
      if (ctrl[CMPEV_BIT_REFSEL])
      begin
         pos_src_ref = REF_AVAIL;
         pos_src_gnd = ~REF_AVAIL;
      end
      else
      begin
         pos_src_pin = POS_PIN_AVAIL;
         pos_src_gnd = ~POS_PIN_AVAIL;
      end
   end

   // One-hot negative pin select, gated by pin availability.
   always_comb
   begin
      neg_src_pin = (4'h1 << chan) & NEG_PIN_AVAIL;
      neg_src_gnd = ~NEG_PIN_AVAIL[chan];
   end

   // The op amp bit drives only the op amp; events ignore it.
   assign opamp_enable = ctrl[CMPEV_BIT_OPAMP];

   // Assertions checking the event, register and routing behaviour.
   AST_ANY_EDGE: assert property (
      ev.edge_sel == CMPEV_EDGE_ANY && $changed(level) && !ev.event_flag
      |=> ctrl[CMPEV_BIT_EVFLAG] && trigger_pulse)
      else $error("Any-change event missed.");

   AST_FALL_EDGE: assert property (
      (ev.edge_sel == CMPEV_EDGE_FALL && !ev.event_flag &&
       (ev.invert ? $rose(level) : $fell(level))) |-> ev.event_req)
      else $error("Falling adjusted edge missed.");

   AST_RISE_EDGE: assert property (
      ev.event_req && ev.edge_sel == CMPEV_EDGE_RISE |->
      (ev.invert ? $fell(level) : $rose(level)))
      else $error("Rising mode event on wrong edge.");

   AST_OFF_MODE: assert property (
      ev.edge_sel == CMPEV_EDGE_OFF |-> !ev.event_req)
      else $error("Event raised in disabled mode.");

   AST_RSVD_ZERO: assert property (
      psel && penable && !pwrite && paddr == CMPEV_OFF_CTRL |->
      prdata[5] == 1'b0 && prdata[3:2] == 2'h0)
      else $error("Unimplemented control bits read nonzero.");

   AST_POS_ROUTE: assert property (
      $onehot({pos_src_ref, pos_src_pin, pos_src_gnd}) &&
      (!pos_src_ref || ctrl[CMPEV_BIT_REFSEL]) &&
      (!pos_src_pin || !ctrl[CMPEV_BIT_REFSEL]))
      else $error("Positive input routing wrong.");

   AST_NEG_ROUTE: assert property (
      $onehot({neg_src_pin, neg_src_gnd}) &&
      (neg_src_gnd || neg_src_pin[chan]))
      else $error("Negative input routing wrong.");

   AST_SRC_GND: assert property (
      pos_src_gnd == (ctrl[CMPEV_BIT_REFSEL] ? !REF_AVAIL : !POS_PIN_AVAIL)
      && neg_src_gnd == !NEG_PIN_AVAIL[chan])
      else $error("Absent source not tied to ground.");

   AST_OPAMP_FREE: assert property (
      opamp_enable && ev.edge_sel == CMPEV_EDGE_ANY && !ev.event_flag &&
      $changed(level) |-> ev.event_req)
      else $error("Op amp enable blocked comparator event.");

   AST_FLAG_HOLD: assert property (
      ev.event_req |=> ctrl[CMPEV_BIT_EVFLAG] &&
      irq_status[CMPEV_IRQ_BIT_CMP] ##0 !ev.event_req)
      else $error("Event flag or interrupt flag not set.");

   AST_FLAG_BLOCK: assert property (
      ev.event_flag |-> !ev.event_req)
      else $error("Event raised while event flag set.");

   AST_TRIG_ONE: assert property (
      trigger_pulse |=> !trigger_pulse)
      else $error("Trigger pulse longer than one cycle.");

   AST_IRQ_LEVEL: assert property (
      irq == |(irq_status & irq_mask))
      else $error("Interrupt does not follow unmasked status.");

   COV_ANY: cover property (
      ev.event_req && ev.edge_sel == CMPEV_EDGE_ANY);
   COV_FALL_INV: cover property (
      ev.event_req && ev.edge_sel == CMPEV_EDGE_FALL && ev.invert);
   COV_CLR_REARM: cover property (
      $fell(ctrl[CMPEV_BIT_EVFLAG]) ##[1:20] ev.event_req);
   COV_IRQ: cover property ($rose(irq));
endmodule
